// [design/tcs_dev.sv]
// Device end: serial slave port giving the master access to internal registers
`timescale 1ns/1ps
// Operation
// - Answer address 01111 plus two strap bits
// - Last address bit zero writes, one reads
// - Strap bits follow AD pin wiring
// - Sample data while clock is high
// - Data falling, clock high means START
// - Data rising, clock high means STOP
// - Master sends address byte first, MSB first
// - Pull data low in matching address acknowledge
// - Master stops after a missing address acknowledge
// - Register address byte received and acknowledged
// - Data byte stored and acknowledged
// - Read after write of address, repeated START
// - Data line stays released when bus idle
// - Clock input only, data open-drain only
// - Master clock at most 400 kHz
module tcs_dev
  import tcs_pkg::*;
#(
  parameter int DW = 8
) (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic NRST,
  // Serial bus
  tcs_i2c_if.dev BUS,
  // Register access
  output logic [DW-1:0] REG_ADDR,
  output logic [DW-1:0] REG_WDATA,
  output logic REG_WE,
  input wire logic [DW-1:0] REG_RDATA,
  // Status
  output logic BUSY,
  output logic [1:0] STRAP
);

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_ADDR = 4'h1,
    ST_ACK_ADDR = 4'h2,
    ST_REG = 4'h3,
    ST_ACK_REG = 4'h4,
    ST_WDATA = 4'h5,
    ST_ACK_WDATA = 4'h6,
    ST_RDATA = 4'h7,
    ST_ACK_RD = 4'h8
  } tcs_state_t;

  tcs_state_t state_q, state_d;
  logic scl_m_q, scl_s_q, scl_p_q;
  logic sda_m_q, sda_s_q, sda_p_q;
  logic ad_m_q, ad_s_q;
  logic [3:0] cand_q, cand_d;
  logic [3:0] cnt_q, cnt_d;
  logic [DW-1:0] sh_q, sh_d;
  logic [DW-1:0] addr_q, addr_d;
  logic [DW-1:0] wdat_q, wdat_d;
  logic drv_q, drv_d;
  logic we_q, we_d;
  logic rw_q, rw_d;
  logic mack_q, mack_d;
  logic busy_q;
  logic [1:0] strap_q;
  logic [1:0] fill_q;

  // Bus events seen on the synchronised lines
  wire scl_rise = scl_s_q & ~scl_p_q;
  wire scl_fall = ~scl_s_q & scl_p_q;
  wire start_ev = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
  wire stop_ev = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;
  wire byte_done = (cnt_q == BYTE_BITS);
  wire rx_state = (state_q == ST_ADDR) || (state_q == ST_REG) || (state_q == ST_WDATA);

  // Strap candidates: each wiring is ruled out once the pin disagrees with it; nothing is
  // ruled out until both synchroniser stages hold real pin levels after reset
  wire sync_full = fill_q[1];
  wire [3:0] cand_keep = {~(ad_s_q ^ sda_s_q), ~(ad_s_q ^ scl_s_q), ad_s_q, ~ad_s_q};
  assign cand_d = sync_full ? (cand_q & cand_keep) : cand_q;
  wire [1:0] strap_w = cand_q[TIE_GND] ? STRAP_GND :
                       cand_q[TIE_VCC] ? STRAP_VCC :
                       cand_q[TIE_SCL] ? STRAP_SCL : STRAP_SDA;

  // Own address check on the received address byte
  wire addr_hit = (sh_q[7:1] == {FIXED_ADDRESS_BITS, strap_w});

  // Synchronisers for the pins and edge history
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      {scl_m_q, scl_s_q, scl_p_q} <= 3'h7;
      {sda_m_q, sda_s_q, sda_p_q} <= 3'h7;
      {ad_m_q, ad_s_q} <= 2'h0;
    end else begin
      {scl_m_q, scl_s_q, scl_p_q} <= {BUS.scl, scl_m_q, scl_s_q};
      {sda_m_q, sda_s_q, sda_p_q} <= {BUS.sda, sda_m_q, sda_s_q};
      {ad_m_q, ad_s_q} <= {BUS.ad, ad_m_q};
    end
  end

  // Protocol sequencer: receives on clock rise, changes data on clock fall
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    sh_d = sh_q;
    addr_d = addr_q;
    wdat_d = wdat_q;
    drv_d = drv_q;
    we_d = 1'b0;
    rw_d = rw_q;
    mack_d = mack_q;
    if (stop_ev) begin
      state_d = ST_IDLE;
      drv_d = 1'b0;
    end else if (start_ev) begin
      state_d = ST_ADDR;
      cnt_d = 4'h0;
      drv_d = 1'b0;
    end else if (scl_rise) begin
      if (rx_state && !byte_done) begin
        sh_d = {sh_q[DW-2:0], sda_s_q};
        cnt_d = cnt_q + 4'h1;
      end else if (state_q == ST_RDATA && !byte_done) begin
        cnt_d = cnt_q + 4'h1;
      end else if (state_q == ST_ACK_RD) begin
        mack_d = sda_s_q;
        if (!sda_s_q) begin
          addr_d = addr_q + 8'h01;
        end
      end
    end else if (scl_fall) begin
      unique case (state_q)
        ST_IDLE: begin
          drv_d = 1'b0;
        end
        ST_ADDR: begin
          if (byte_done) begin
            if (addr_hit) begin
              state_d = ST_ACK_ADDR;
              drv_d = 1'b1;
              rw_d = sh_q[0];
            end else begin
              state_d = ST_IDLE;
            end
          end
        end
        ST_ACK_ADDR: begin
          cnt_d = 4'h0;
          if (rw_q == DIR_READ) begin
            state_d = ST_RDATA;
            sh_d = REG_RDATA;
            drv_d = ~REG_RDATA[DW-1];
          end else begin
            state_d = ST_REG;
            drv_d = 1'b0;
          end
        end
        ST_REG: begin
          if (byte_done) begin
            addr_d = sh_q;
            state_d = ST_ACK_REG;
            drv_d = 1'b1;
          end
        end
        ST_ACK_REG: begin
          state_d = ST_WDATA;
          cnt_d = 4'h0;
          drv_d = 1'b0;
        end
        ST_WDATA: begin
          if (byte_done) begin
            wdat_d = sh_q;
            we_d = 1'b1;
            state_d = ST_ACK_WDATA;
            drv_d = 1'b1;
          end
        end
        ST_ACK_WDATA: begin
          state_d = ST_WDATA;
          cnt_d = 4'h0;
          drv_d = 1'b0;
          addr_d = addr_q + 8'h01;
        end
        ST_RDATA: begin
          if (byte_done) begin
            state_d = ST_ACK_RD;
            drv_d = 1'b0;
          end else begin
            sh_d = {sh_q[DW-2:0], 1'b0};
            drv_d = ~sh_q[DW-2];
          end
        end
        ST_ACK_RD: begin
          if (!mack_q) begin
            state_d = ST_RDATA;
            sh_d = REG_RDATA;
            drv_d = ~REG_RDATA[DW-1];
            cnt_d = 4'h0;
          end else begin
            state_d = ST_IDLE;
            drv_d = 1'b0;
          end
        end
        default: begin
          state_d = ST_IDLE;
          drv_d = 1'b0;
        end
      endcase
    end
  end

  // Sequencer registers
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      state_q <= ST_IDLE;
      cnt_q <= 4'h0;
      sh_q <= '0;
      addr_q <= '0;
      wdat_q <= '0;
      drv_q <= 1'b0;
      we_q <= 1'b0;
      rw_q <= DIR_WRITE;
      mack_q <= 1'b1;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      addr_q <= addr_d;
      wdat_q <= wdat_d;
      drv_q <= drv_d;
      we_q <= we_d;
      rw_q <= rw_d;
      mack_q <= mack_d;
    end
  end

  // Strap tracking and status
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      cand_q <= 4'hF;
      fill_q <= 2'h0;
      strap_q <= 2'h0;
      busy_q <= 1'b0;
    end else begin
      cand_q <= cand_d;
      fill_q <= sync_full ? fill_q : fill_q + 2'h1;
      strap_q <= strap_w;
      busy_q <= (state_d != ST_IDLE);
    end
  end

  // Open-drain data pin: the output bit stays low, only the enable moves
  assign BUS.dev_sda_o = 1'b0;
  assign BUS.dev_sda_oe_n = ~drv_q;
  assign REG_ADDR = addr_q;
  assign REG_WDATA = wdat_q;
  assign REG_WE = we_q;
  assign BUSY = busy_q;
  assign STRAP = strap_q;

endmodule

// [design/tcs_pkg.sv]
// Shared constants for the touch controller serial slave port and its master
package tcs_pkg;
  // Fixed upper part of the 7-bit slave address
  localparam logic [4:0] FIXED_ADDRESS_BITS = 5'h0F;
  // Direction bit codes
  localparam logic DIR_WRITE = 1'h0;
  localparam logic DIR_READ = 1'h1;
  // Strap pin connection codes (selection used by the interface)
  localparam logic [1:0] TIE_GND = 2'h0;
  localparam logic [1:0] TIE_VCC = 2'h1;
  localparam logic [1:0] TIE_SCL = 2'h2;
  localparam logic [1:0] TIE_SDA = 2'h3;
  // Strapped address bits produced by each connection
  localparam logic [1:0] STRAP_GND = 2'h0;
  localparam logic [1:0] STRAP_VCC = 2'h3;
  localparam logic [1:0] STRAP_SCL = 2'h1;
  localparam logic [1:0] STRAP_SDA = 2'h2;
  // Bits in one byte phase before the acknowledge slot
  localparam logic [3:0] BYTE_BITS = 4'h8;
  // Clock and serial clock timing
  localparam int CLOCK_HZ = 200_000_000;
  localparam int SCL_MAX_KHZ = 400;
  localparam int QUARTER_CYC = (CLOCK_HZ + 4 * SCL_MAX_KHZ * 1000 - 1) / (4 * SCL_MAX_KHZ * 1000);
  localparam logic [7:0] QUARTER_LAST = 8'(QUARTER_CYC - 1);
endpackage

// [design/tcs_i2c_if.sv]
// Two-wire bus between the slave port and its master, with the strap pin
`timescale 1ns/1ps
interface tcs_i2c_if;
  import tcs_pkg::*;
  logic host_scl_o;
  logic host_scl_oe_n;
  logic host_sda_o;
  logic host_sda_oe_n;
  logic dev_sda_o;
  logic dev_sda_oe_n;
  logic [1:0] ad_tie;
  logic scl;
  logic sda;
  logic ad;
  // Wired-AND with pull-ups: a released line reads high
  assign scl = host_scl_oe_n | host_scl_o;
  assign sda = (host_sda_oe_n | host_sda_o) & (dev_sda_oe_n | dev_sda_o);
  // Strap pin wiring chosen by the bench
  assign ad = (ad_tie == TIE_GND) ? 1'b0 : (ad_tie == TIE_VCC) ? 1'b1 :
              (ad_tie == TIE_SCL) ? scl : sda;
  modport dev (input scl, input sda, input ad, output dev_sda_o, output dev_sda_oe_n);
  modport host (input scl, input sda, output host_scl_o, output host_scl_oe_n,
                output host_sda_o, output host_sda_oe_n);
endinterface

// [design/tcs_host.sv]
// Master end: drives the serial clock and runs single-byte register transfers
`timescale 1ns/1ps
module tcs_host
  import tcs_pkg::*;
#(
  parameter int DW = 8
) (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic NRST,
  // Serial bus
  tcs_i2c_if.host BUS,
  // Command port
  input wire logic CMD_VALID,
  input wire logic CMD_READ,
  input wire logic [1:0] CMD_STRAP,
  input wire logic [DW-1:0] CMD_REG,
  input wire logic [DW-1:0] CMD_WDATA,
  output logic CMD_READY,
  // Result
  output logic DONE,
  output logic NACK,
  output logic [DW-1:0] RDATA
);

  typedef enum logic [1:0] {
    H_IDLE = 2'h0,
    H_START = 2'h1,
    H_BYTE = 2'h2,
    H_STOP = 2'h3
  } tcs_hstate_t;

  tcs_hstate_t state_q, state_d;
  logic [7:0] div_q;
  logic tick_q;
  logic sda_m_q, sda_s_q;
  logic [1:0] qtr_q, qtr_d;
  logic [3:0] bit_q, bit_d;
  logic [2:0] seg_q, seg_d;
  logic [DW-1:0] sh_q, sh_d;
  logic ack_q, ack_d;
  logic rd_q, rd_d;
  logic [1:0] strap_q, strap_d;
  logic [DW-1:0] reg_q, reg_d, wdat_q, wdat_d;
  logic scl_low_q, scl_low_d, sda_low_q, sda_low_d;
  logic ready_q, done_q, done_d, nack_q, nack_d;
  logic [DW-1:0] rdata_q, rdata_d;

  // Address byte to send in each address segment of a transfer, receive-segment and last-bit flags
  wire [DW-1:0] byte_addr_w = {FIXED_ADDRESS_BITS, strap_q, DIR_WRITE};
  wire [DW-1:0] byte_addr_r = {FIXED_ADDRESS_BITS, strap_q, DIR_READ};
  wire rx_seg = (seg_q == 3'h4);
  wire last_bit = (bit_q == BYTE_BITS);

  // Quarter-bit enable: four per serial clock period, at most 400 kHz
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      div_q <= 8'h00;
      tick_q <= 1'b0;
    end else begin
      div_q <= (div_q == QUARTER_LAST) ? 8'h00 : div_q + 8'h01;
      tick_q <= (div_q == QUARTER_LAST);
    end
  end

  // Data pin synchroniser
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      {sda_m_q, sda_s_q} <= 2'h3;
    end else begin
      {sda_m_q, sda_s_q} <= {BUS.sda, sda_m_q};
    end
  end

  // Transfer sequencer
  always_comb begin
    state_d = state_q;
    qtr_d = qtr_q;
    bit_d = bit_q;
    seg_d = seg_q;
    sh_d = sh_q;
    ack_d = ack_q;
    rd_d = rd_q;
    strap_d = strap_q;
    reg_d = reg_q;
    wdat_d = wdat_q;
    scl_low_d = scl_low_q;
    sda_low_d = sda_low_q;
    done_d = 1'b0;
    nack_d = nack_q;
    rdata_d = rdata_q;
    if (state_q == H_IDLE) begin
      if (CMD_VALID && ready_q) begin
        state_d = H_START;
        qtr_d = 2'h0;
        seg_d = 3'h0;
        rd_d = CMD_READ;
        strap_d = CMD_STRAP;
        reg_d = CMD_REG;
        wdat_d = CMD_WDATA;
        nack_d = 1'b0;
      end
    end else if (tick_q) begin
      qtr_d = qtr_q + 2'h1;
      unique case (state_q)
        H_START: begin
          unique case (qtr_q)
            2'h0: sda_low_d = 1'b0;
            2'h1: scl_low_d = 1'b0;
            2'h2: sda_low_d = 1'b1;
            2'h3: begin
              scl_low_d = 1'b1;
              state_d = H_BYTE;
              bit_d = 4'h0;
              sh_d = (seg_q == 3'h3) ? byte_addr_r : byte_addr_w;
            end
          endcase
        end
        H_BYTE: begin
          unique case (qtr_q)
            2'h0: sda_low_d = !rx_seg && !last_bit && !sh_q[DW-1];
            2'h1: scl_low_d = 1'b0;
            2'h2: begin
              if (!last_bit) begin
                sh_d = {sh_q[DW-2:0], sda_s_q};
              end else begin
                ack_d = sda_s_q;
              end
            end
            2'h3: begin
              scl_low_d = 1'b1;
              bit_d = bit_q + 4'h1;
              if (last_bit) begin
                bit_d = 4'h0;
                if (!rx_seg && ack_q) begin
                  nack_d = 1'b1;
                  state_d = H_STOP;
                end else if (seg_q == 3'h0) begin
                  seg_d = 3'h1;
                  sh_d = reg_q;
                end else if (seg_q == 3'h1 && rd_q) begin
                  seg_d = 3'h3;
                  state_d = H_START;
                end else if (seg_q == 3'h1) begin
                  seg_d = 3'h2;
                  sh_d = wdat_q;
                end else if (seg_q == 3'h3) begin
                  seg_d = 3'h4;
                end else begin
                  rdata_d = rx_seg ? sh_q : rdata_q;
                  state_d = H_STOP;
                end
              end
            end
          endcase
        end
        H_STOP: begin
          unique case (qtr_q)
            2'h0: sda_low_d = 1'b1;
            2'h1: scl_low_d = 1'b0;
            2'h2: sda_low_d = 1'b0;
            2'h3: begin
              state_d = H_IDLE;
              done_d = 1'b1;
            end
          endcase
        end
        default: state_d = H_IDLE;
      endcase
    end
  end

  // Sequencer registers
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      state_q <= H_IDLE;
      {qtr_q, bit_q, seg_q} <= 9'h000;
      {sh_q, reg_q, wdat_q, rdata_q} <= '0;
      {ack_q, rd_q, strap_q} <= 4'h8;
      {scl_low_q, sda_low_q, done_q, nack_q} <= 4'h0;
      ready_q <= 1'b0;
    end else begin
      state_q <= state_d;
      {qtr_q, bit_q, seg_q} <= {qtr_d, bit_d, seg_d};
      {sh_q, reg_q, wdat_q, rdata_q} <= {sh_d, reg_d, wdat_d, rdata_d};
      {ack_q, rd_q, strap_q} <= {ack_d, rd_d, strap_d};
      {scl_low_q, sda_low_q, done_q, nack_q} <= {scl_low_d, sda_low_d, done_d, nack_d};
      ready_q <= (state_d == H_IDLE);
    end
  end

  // Open-drain pins: output bits stay low, enables pull the lines
  assign BUS.host_scl_o = 1'b0;
  assign BUS.host_scl_oe_n = ~scl_low_q;
  assign BUS.host_sda_o = 1'b0;
  assign BUS.host_sda_oe_n = ~sda_low_q;
  assign CMD_READY = ready_q;
  assign DONE = done_q;
  assign NACK = nack_q;
  assign RDATA = rdata_q;

endmodule

// [test/tcs_asserts.sv]
// Protocol checks on the serial bus between the slave port and its master
`timescale 1ns/1ps
module tcs_asserts (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic NRST,
  // Bus signals
  input wire logic host_scl_o,
  input wire logic host_scl_oe_n,
  input wire logic host_sda_o,
  input wire logic host_sda_oe_n,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe_n,
  input wire logic scl,
  input wire logic sda
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!NRST);
  logic scl_p_q;
  logic sda_p_q;
  logic idle_q;
  logic [3:0] rise_cnt_q;
  logic [15:0] per_q;
  logic [15:0] hi_q;
  // Bus conditions seen from the sampled lines
  wire start_w = scl & scl_p_q & sda_p_q & !sda;
  wire stop_w = scl & scl_p_q & !sda_p_q & sda;
  wire rise_w = scl & !scl_p_q;
  // Line history, idle flag, clock period and high-time counters
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
      idle_q <= 1'b1;
      rise_cnt_q <= 4'h0;
      per_q <= 16'hFFFF;
      hi_q <= 16'h0;
    end else begin
      scl_p_q <= scl;
      sda_p_q <= sda;
      idle_q <= stop_w | (idle_q & !start_w);
      rise_cnt_q <= start_w ? 4'h0 :
                    (rise_w && rise_cnt_q != 4'hF) ? rise_cnt_q + 4'h1 : rise_cnt_q;
      per_q <= rise_w ? 16'h0 : (per_q == 16'hFFFF) ? per_q : per_q + 16'h1;
      hi_q <= !scl ? 16'h0 : (hi_q == 16'hFFFF) ? hi_q : hi_q + 16'h1;
    end
  end
  property p_dev_od; !dev_sda_o; endproperty
  a_dev_od: assert property (p_dev_od) else $error("device data output not open drain");
  property p_host_od; !host_sda_o && !host_scl_o; endproperty
  a_host_od: assert property (p_host_od) else $error("master output not open drain");
  property p_dev_stable; $changed(dev_sda_oe_n) |-> !scl; endproperty
  a_dev_stable: assert property (p_dev_stable) else $error("device changed data while clock high");
  property p_first_drive; $fell(dev_sda_oe_n) |-> rise_cnt_q >= 4'h8; endproperty
  a_first_drive: assert property (p_first_drive) else $error("device drove before address done");
  property p_ack_held; $fell(dev_sda_oe_n) |-> !dev_sda_oe_n throughout (##[1:300] $rose(scl)); endproperty
  a_ack_held: assert property (p_ack_held) else $error("device low not held into clock pulse");
  property p_stop_release; stop_w |-> dev_sda_oe_n [*8]; endproperty
  a_stop_release: assert property (p_stop_release) else $error("device drives after stop");
  property p_idle; idle_q && !start_w |-> host_sda_oe_n && dev_sda_oe_n; endproperty
  a_idle: assert property (p_idle) else $error("data pulled low on idle bus");
  property p_scl_rate; $rose(scl) |-> per_q >= 16'h1F3; endproperty
  a_scl_rate: assert property (p_scl_rate) else $error("serial clock period too short");
  property p_scl_high; $fell(scl) |-> hi_q >= 16'h8C; endproperty
  a_scl_high: assert property (p_scl_high) else $error("serial clock high phase too short");
endmodule

// [test/touch_controller_i2c_slave_port_tb.sv]
// Self-checking bench joining the slave port to its master over the bus
`timescale 1ns/1ps
module touch_controller_i2c_slave_port_tb;
  import tcs_pkg::*;
  logic clock;
  logic nrst;
  logic cmd_valid;
  logic cmd_read;
  logic [1:0] cmd_strap;
  logic [7:0] cmd_reg;
  logic [7:0] cmd_wdata;
  logic cmd_ready;
  logic done;
  logic nack;
  logic [7:0] rdata;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_we;
  logic busy;
  logic [1:0] strap;
  logic [7:0] regs_q [256];
  logic [7:0] last_addr;
  logic [7:0] last_data;
  int we_cnt;
  int failures;
  int num_checks;
  tcs_i2c_if u_tcs_i2c_if();
  tcs_dev u_tcs_dev (.CLOCK(clock), .NRST(nrst), .BUS(u_tcs_i2c_if), .REG_ADDR(reg_addr),
    .REG_WDATA(reg_wdata), .REG_WE(reg_we), .REG_RDATA(regs_q[reg_addr]), .BUSY(busy),
    .STRAP(strap));
  tcs_host u_tcs_host (.CLOCK(clock), .NRST(nrst), .BUS(u_tcs_i2c_if), .CMD_VALID(cmd_valid),
    .CMD_READ(cmd_read), .CMD_STRAP(cmd_strap), .CMD_REG(cmd_reg), .CMD_WDATA(cmd_wdata),
    .CMD_READY(cmd_ready), .DONE(done), .NACK(nack), .RDATA(rdata));
  tcs_asserts u_tcs_asserts (.CLOCK(clock), .NRST(nrst),
    .host_scl_o(u_tcs_i2c_if.host_scl_o), .host_scl_oe_n(u_tcs_i2c_if.host_scl_oe_n),
    .host_sda_o(u_tcs_i2c_if.host_sda_o), .host_sda_oe_n(u_tcs_i2c_if.host_sda_oe_n),
    .dev_sda_o(u_tcs_i2c_if.dev_sda_o), .dev_sda_oe_n(u_tcs_i2c_if.dev_sda_oe_n),
    .scl(u_tcs_i2c_if.scl), .sda(u_tcs_i2c_if.sda));
  // Clock at 200 MHz
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  // Register array behind the port, with a record of each write
  always @(posedge clock) begin
    if (reg_we === 1'b1) begin
      regs_q[reg_addr] <= reg_wdata;
      last_addr <= reg_addr;
      last_data <= reg_wdata;
      we_cnt <= we_cnt + 1;
    end
  end
  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic results();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic do_reset();
    @(negedge clock);
    nrst = 1'b0;
    repeat (20) @(negedge clock);
    nrst = 1'b1;
  endtask
  // One master command, waiting on ready and then on completion
  task automatic do_cmd(input logic rd, input logic [1:0] st, input logic [7:0] ra,
                        input logic [7:0] wd);
    int n;
    logic bz;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 100) begin
      @(negedge clock);
      n++;
    end
    cmd_valid = 1'b1;
    cmd_read = rd;
    cmd_strap = st;
    cmd_reg = ra;
    cmd_wdata = wd;
    @(negedge clock);
    cmd_valid = 1'b0;
    check("ready low", 8'h00, {7'h0, cmd_ready});
    n = 0;
    bz = 1'b0;
    while (done !== 1'b1 && n < 30000) begin
      @(negedge clock);
      bz = bz | busy;
      n++;
    end
    check("done", 8'h01, {7'h0, done});
    check("ready", 8'h01, {7'h0, cmd_ready});
    check("busy seen", 8'h01, {7'h0, bz});
  endtask
  // Watchdog against a hung transfer
  initial begin
    repeat (100000) @(posedge clock);
    failures++;
    $display("mismatch watchdog expected done seen timeout");
    results();
  end
  // Main sequence
  initial begin
    logic [1:0] ties [4];
    logic [1:0] exp_strap [4];
    ties = '{TIE_GND, TIE_VCC, TIE_SCL, TIE_SDA};
    exp_strap = '{2'h0, 2'h3, 2'h1, 2'h2};
    nrst = 1'b0;
    cmd_valid = 1'b0;
    cmd_read = 1'b0;
    cmd_strap = 2'h0;
    cmd_reg = 8'h00;
    cmd_wdata = 8'h00;
    we_cnt = 0;
    failures = 0;
    num_checks = 0;
    u_tcs_i2c_if.ad_tie = TIE_GND;
    for (int i = 0; i < 256; i++) begin
      regs_q[i] = 8'h00;
    end
    // One write per strap wiring, with the matching strapped bits
    for (int t = 0; t < 4; t++) begin
      u_tcs_i2c_if.ad_tie = ties[t];
      do_reset();
      do_cmd(DIR_WRITE, exp_strap[t], 8'h10 + 8'(t), 8'hA0 + 8'(t));
      check("nack", 8'h00, {7'h0, nack});
      check("strap", {6'h0, exp_strap[t]}, {6'h0, strap});
      check("reg addr", 8'h10 + 8'(t), last_addr);
      check("reg data", 8'hA0 + 8'(t), last_data);
      check("writes", 8'(t + 1), 8'(we_cnt));
      check("busy", 8'h00, {7'h0, busy});
    end
    // Read back through address write, restart and read address
    do_cmd(DIR_READ, 2'h2, 8'h11, 8'h00);
    check("read data", 8'hA1, rdata);
    check("read nack", 8'h00, {7'h0, nack});
    check("read writes", 8'h04, 8'(we_cnt));
    check("read busy", 8'h00, {7'h0, busy});
    // Wrong strapped bits: no acknowledge and no write
    do_cmd(DIR_WRITE, 2'h0, 8'h12, 8'h55);
    check("miss nack", 8'h01, {7'h0, nack});
    check("miss writes", 8'h04, 8'(we_cnt));
    check("miss busy", 8'h00, {7'h0, busy});
    results();
  end
endmodule
